/* shared/pcf_regs.svh */
`ifndef PCF_REGS_SVH
`define PCF_REGS_SVH
// Register indices (byte address = index * 4)
`define PCF_IDX_IDENT        6'h00
`define PCF_IDX_CMDSTAT      6'h01
// Function number that selects this register set
`define PCF_FUNC0            3'h0
// Command field positions
`define PCF_CMD_MEM_BIT      1
`define PCF_CMD_MASTER_BIT   2
`define PCF_CMD_PERR_BIT     6
`define PCF_CMD_SERR_BIT     8
// Status field positions
`define PCF_ST_DPAR_BIT      31
`define PCF_ST_SSERR_BIT     30
`define PCF_ST_RMABT_BIT     29
`define PCF_ST_RTABT_BIT     28
`define PCF_ST_STABT_BIT     27
`define PCF_ST_DPREP_BIT     24
`define PCF_ST_FAST_BIT      23
// Fixed read-only fields
`define PCF_DEVSEL_MEDIUM    2'h1
`define PCF_FAST_VAL         1'h1
// Writable command mask and sticky status mask
`define PCF_CMD_RW_MASK      16'h0146
`define PCF_ST_W1C_MASK      16'hF900
`endif

/* shared/pcf_pkg.sv */
package pcf_pkg;
	typedef enum logic [2:0] {
		PCF_IDLE = 3'b001,
		PCF_DATA = 3'b010,
		PCF_TURN = 3'b100
	} pcf_state_e;
endpackage

/* hdl/pcf_sync.sv */
`timescale 1ns/100ps
// Two-flop synchroniser for pin-level event inputs
module pcf_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,  // Clock
	input  wire logic         rst_b, // Sync reset, low
	input  wire logic [W-1:0] din,   // Asynchronous input
	output logic      [W-1:0] dout   // Synchronised level
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s1_d;
	logic [W-1:0] s2_d;

	always_comb begin
		s1_d = din;
		s2_d = s1_q;
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
		end
	end

	assign dout = s2_q;
endmodule

/* hdl/pcf_status.sv */
`timescale 1ns/100ps
`include "pcf_regs.svh"
// Sticky error flags: hardware set wins over write-one-clear
module pcf_status (
	input  wire logic       mclk,    // Clock
	input  wire logic       rst_b,   // Sync reset, low
	input  wire logic [5:0] set_ev,  // Set events, one per flag
	input  wire logic [5:0] clr_req, // Write-one-clear pulses
	output logic      [5:0] flags    // Sticky flag levels
);
	logic [5:0] fl_q;
	logic [5:0] fl_d;

	always_comb begin
		// [R10] write one clears
		fl_d = (fl_q & ~clr_req) | set_ev;
	end

	always_ff @(posedge mclk) begin
		// [R23] flags reset to zero
		if (!rst_b)
			fl_q <= 6'h00;
		else
			fl_q <= fl_d;
	end

	assign flags = fl_q;

	sticky_set_a: assert property ( // [R10]
		@(posedge mclk) disable iff (!rst_b)
		set_ev[0] |=> fl_q[0])
		else $error("sticky flag lost its set event");
	sticky_clr_a: assert property ( // [R10]
		@(posedge mclk) disable iff (!rst_b)
		(clr_req[1] && !set_ev[1]) |=> !fl_q[1])
		else $error("sticky flag not cleared by write one");
endmodule

/* hdl/pcf_cfg.sv */
`timescale 1ns/100ps
`include "pcf_regs.svh"
// Notes on behaviour
// [R1] Type 0 config: address bits 10..8 pick function; zero selects this set.
// [R2] Claim only with select high and address bits 1..0 zero.
// [R3] Config registers reachable at all times, never locked out.
// [R4] Burst config reads and writes step through consecutive registers.
// [R5] Writes to reserved or read-only bits complete, data dropped.
// [R6] Reserved or unimplemented bits read back as zero.
// [R7] Address bits 7..2 pick register; byte enables pick lanes.
// [R8] No card pointer, self-test, cache size, ROM base or user slots.
// [R9] Read/write bits clear to zero on bus reset.
// [R10] Sticky status: writing one clears, writing zero keeps.
// [R11] Offset zero read-only: device id high, maker id low.
// [R12] Command all zero: only configuration cycles answered.
// [R13] Status 31 set on any parity error, regardless of enable.
// [R14] Status 30 set when error line asserted; command 8 enables it. Code also needs command 6 set.
// [R15] Status 29 on master abort, 28 on received target abort.
// [R16] Address parity error as target: target abort, set status 27.
// [R17] Medium select timing, status 26..25 read as 01.
// [R18] Status 24 on data parity report, only with parity response on.
// [R19] Status 23 reads constant one: fast back-to-back capable.
// [R20] Command 6 gates parity error reporting.
// [R21] Master cycles start only while command 2 is one.
// [R22] Memory decode only while command 1 is one.
// [R23] Sticky error flags return to zero on bus reset.
module pcf_cfg #(
	parameter logic [15:0] DEVICE_ID = 16'h0001, // Arbitrary value
	parameter logic [15:0] MAKER_ID  = 16'h0002  // Arbitrary value
) (
	input  wire logic        mclk,        // Bus clock
	input  wire logic        rst_b,       // Bus reset, low
	input  wire logic        cfg_start,   // Config cycle address phase
	input  wire logic        cfg_write,   // Config cycle is a write
	input  wire logic        idsel,       // Device select pin
	input  wire logic [10:0] cfg_addr,    // Address bits 10..0
	input  wire logic        data_valid,  // Data phase beat present
	input  wire logic        data_last,   // Final data phase
	input  wire logic [3:0]  byte_en_b,   // Byte enables, low active
	input  wire logic [31:0] wdata,       // Write data
	input  wire logic        addr_perr,   // Address parity error pin
	input  wire logic        data_perr,   // Data parity error pin
	input  wire logic        mst_read,    // Own master cycle is a read
	input  wire logic        tgt_perr,    // Target signalled parity err
	input  wire logic        mst_mabort,  // Own master ended in m-abort
	input  wire logic        mst_tabort,  // Own master ended in t-abort
	input  wire logic        mst_req,     // Core wants to master
	input  wire logic        mem_hit,     // Memory address matches bar
	output logic             cfg_claim,   // Claiming config cycle
	output logic [31:0]      rdata,       // Read data
	output logic             rdata_vld,   // Read data valid
	output logic             tgt_abort,   // Target abort request
	output logic             serr_out,    // System error drive
	output logic             perr_out,    // Parity error drive
	output logic             mst_go,      // Master start permitted
	output logic             mem_claim    // Memory decode claim
);
	// ----------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------
	logic [5:0] pin_s;

	pcf_sync #(.W(6)) u_sync (
		.mclk  (mclk),
		.rst_b (rst_b),
		.din   ({addr_perr, data_perr, tgt_perr, mst_mabort,
		         mst_tabort, mst_read}),
		.dout  (pin_s)
	);

	logic ap_s, dp_s, tp_s, ma_s, ta_s, rd_s;
	always_comb begin
		{ap_s, dp_s, tp_s, ma_s, ta_s, rd_s} = pin_s;
	end

	// ----------------------------------------------------------
	// Transaction state
	// ----------------------------------------------------------
	pcf_pkg::pcf_state_e st_q, st_d;
	logic [5:0]  idx_q, idx_d;
	logic        wr_q, wr_d;
	logic [15:0] cmd_q, cmd_d;
	logic        claim_q, claim_d;
	logic [31:0] rdata_q, rdata_d;
	logic        rvld_q, rvld_d;
	logic        tabt_q, tabt_d;
	logic        serr_q, serr_d;
	logic        perr_q, perr_d;
	logic        mgo_q, mgo_d;
	logic        mem_q, mem_d;
	logic [5:0]  st_set, st_clr;
	logic [5:0]  flags;

	function automatic logic [31:0] lane_mask(input logic [3:0] be_b);
		lane_mask = {{8{~be_b[3]}}, {8{~be_b[2]}},
		             {8{~be_b[1]}}, {8{~be_b[0]}}};
	endfunction

	function automatic logic [31:0] read_word(input logic [5:0] idx,
		input logic [15:0] cmd, input logic [5:0] fl);
		read_word = 32'h0000_0000;
		// [R11] identity word
		if (idx == `PCF_IDX_IDENT)
			read_word = {DEVICE_ID, MAKER_ID};
		else if (idx == `PCF_IDX_CMDSTAT) begin
			read_word[15:0] = cmd & `PCF_CMD_RW_MASK;
			read_word[`PCF_ST_DPAR_BIT:`PCF_ST_STABT_BIT] = fl[5:1];
			// [R17] medium select timing
			read_word[26:25] = `PCF_DEVSEL_MEDIUM;
			read_word[`PCF_ST_DPREP_BIT] = fl[0];
			// [R19] fast back-to-back flag
			read_word[`PCF_ST_FAST_BIT] = `PCF_FAST_VAL;
		end
		// [R6] unimplemented reads zero
		// [R8] unsupported slots fall here
	endfunction

	logic        hit;
	logic [31:0] wmask;
	logic        cmd_on;

	always_comb begin
		st_d    = st_q;
		idx_d   = idx_q;
		wr_d    = wr_q;
		cmd_d   = cmd_q;
		claim_d = 1'b0;
		rvld_d  = 1'b0;
		rdata_d = 32'h0000_0000;
		st_clr  = 6'h00;
		wmask   = lane_mask(byte_en_b);
		// [R1] function decode and [R2] select qualification
		hit = cfg_start && idsel && (cfg_addr[1:0] == 2'h0) &&
		      (cfg_addr[10:8] == `PCF_FUNC0);
		// [R3] no lockout on command state
		case (st_q)
			pcf_pkg::PCF_IDLE: begin
				if (hit) begin
					st_d    = pcf_pkg::PCF_DATA;
					// [R7] register index from bits 7..2
					idx_d   = cfg_addr[7:2];
					wr_d    = cfg_write;
					claim_d = 1'b1;
				end
			end
			pcf_pkg::PCF_DATA: begin
				claim_d = 1'b1;
				if (data_valid) begin
					if (wr_q) begin
						// [R5] only writable bits stored
						if (idx_q == `PCF_IDX_CMDSTAT) begin
							cmd_d = (cmd_q & ~(wmask[15:0] & `PCF_CMD_RW_MASK))
							      | (wdata[15:0] & wmask[15:0]
							         & `PCF_CMD_RW_MASK);
							st_clr = {wdata[31:27], wdata[24]}
							       & {wmask[31:27], wmask[24]};
						end
					end else begin
						rdata_d = read_word(idx_q, cmd_q, flags)
						        & wmask;
						rvld_d  = 1'b1;
					end
					// [R4] burst advances register
					idx_d = idx_q + 6'h01;
					if (data_last)
						st_d = pcf_pkg::PCF_TURN;
				end
			end
			pcf_pkg::PCF_TURN: begin
				st_d = pcf_pkg::PCF_IDLE;
			end
			default: st_d = pcf_pkg::PCF_IDLE;
		endcase
		cmd_on = |cmd_q;
		// [R20] parity reporting gate
		perr_d = cmd_q[`PCF_CMD_PERR_BIT] && dp_s;
		// [R14] error line needs enable
		serr_d = cmd_q[`PCF_CMD_SERR_BIT] && cmd_q[`PCF_CMD_PERR_BIT]
		         && ap_s;
		// [R16] address parity error aborts
		tabt_d = ap_s && cmd_on;
		// [R21] master enable gate
		mgo_d = mst_req && cmd_q[`PCF_CMD_MASTER_BIT];
		// [R22] memory decode gate, [R12] silent when off
		mem_d = mem_hit && cmd_q[`PCF_CMD_MEM_BIT];
		// [R13] parity any, [R14] error line, [R15] aborts
		st_set[5] = ap_s || dp_s;
		st_set[4] = serr_d;
		st_set[3] = ma_s;
		st_set[2] = ta_s;
		st_set[1] = tabt_d;
		// [R18] data parity reported when enabled
		st_set[0] = cmd_q[`PCF_CMD_PERR_BIT] &&
		            ((dp_s && rd_s) || (tp_s && !rd_s));
	end

	pcf_status u_status (
		.mclk    (mclk),
		.rst_b   (rst_b),
		.set_ev  (st_set),
		.clr_req (st_clr),
		.flags   (flags)
	);

	always_ff @(posedge mclk) begin
		// [R9] read/write bits reset to zero
		if (!rst_b) begin
			st_q    <= pcf_pkg::PCF_IDLE;
			idx_q   <= 6'h00;
			wr_q    <= 1'b0;
			cmd_q   <= 16'h0000;
			claim_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rvld_q  <= 1'b0;
			tabt_q  <= 1'b0;
			serr_q  <= 1'b0;
			perr_q  <= 1'b0;
			mgo_q   <= 1'b0;
			mem_q   <= 1'b0;
		end else begin
			st_q    <= st_d;
			idx_q   <= idx_d;
			wr_q    <= wr_d;
			cmd_q   <= cmd_d;
			claim_q <= claim_d;
			rdata_q <= rdata_d;
			rvld_q  <= rvld_d;
			tabt_q  <= tabt_d;
			serr_q  <= serr_d;
			perr_q  <= perr_d;
			mgo_q   <= mgo_d;
			mem_q   <= mem_d;
		end
	end

	assign cfg_claim = claim_q;
	assign rdata     = rdata_q;
	assign rdata_vld = rvld_q;
	assign tgt_abort = tabt_q;
	assign serr_out  = serr_q;
	assign perr_out  = perr_q;
	assign mst_go    = mgo_q;
	assign mem_claim = mem_q;

	// ----------------------------------------------------------
	// Checks
	// ----------------------------------------------------------
	func_sel_a: assert property ( // [R1]
		@(posedge mclk) disable iff (!rst_b)
		(st_q == pcf_pkg::PCF_IDLE && cfg_start && cfg_addr[10:8] != 3'h0)
		|=> !cfg_claim)
		else $error("claimed other function");
	idsel_qual_a: assert property ( // [R2]
		@(posedge mclk) disable iff (!rst_b)
		(st_q == pcf_pkg::PCF_IDLE && cfg_start && !idsel) |=> !cfg_claim)
		else $error("claimed without select");
	low_bits_a: assert property ( // [R2]
		@(posedge mclk) disable iff (!rst_b)
		(st_q == pcf_pkg::PCF_IDLE && cfg_start && cfg_addr[1:0] != 2'h0)
		|=> !cfg_claim)
		else $error("claimed with low address bits set");
	ident_ro_a: assert property ( // [R11]
		@(posedge mclk) disable iff (!rst_b)
		(rvld_d && idx_q == 6'h00 && byte_en_b == 4'h0)
		|=> rdata == {DEVICE_ID, MAKER_ID})
		else $error("identity word wrong");
	// Bit 24 sits between the fixed fields and is sticky, so not checked
	decode_time_a: assert property ( // [R17]
		@(posedge mclk) disable iff (!rst_b)
		(rvld_d && idx_q == 6'h01 && byte_en_b == 4'h0)
		|=> rdata[26:25] == 2'b01)
		else $error("select timing bits wrong");
	fast_flag_a: assert property ( // [R19]
		@(posedge mclk) disable iff (!rst_b)
		(rvld_d && idx_q == 6'h01 && byte_en_b == 4'h0)
		|=> rdata[23])
		else $error("fast back-to-back flag not set");
	burst_step_a: assert property ( // [R4]
		@(posedge mclk) disable iff (!rst_b)
		(st_q == pcf_pkg::PCF_DATA && data_valid)
		|=> idx_q == $past(idx_q) + 6'h01)
		else $error("burst did not advance");
	master_gate_a: assert property ( // [R21]
		@(posedge mclk) disable iff (!rst_b)
		mst_go |-> $past(cmd_q[2]))
		else $error("master start while disabled");
	mem_gate_a: assert property ( // [R22]
		@(posedge mclk) disable iff (!rst_b)
		mem_claim |-> $past(cmd_q[1]))
		else $error("memory decode while disabled");
	perr_gate_a: assert property ( // [R20]
		@(posedge mclk) disable iff (!rst_b)
		perr_out |-> $past(cmd_q[6]))
		else $error("parity reported while disabled");
	dpar_set_a: assert property ( // [R13]
		@(posedge mclk) disable iff (!rst_b)
		(ap_s || dp_s) |=> flags[5])
		else $error("parity flag not set");
	serr_gate_a: assert property ( // [R14]
		@(posedge mclk) disable iff (!rst_b)
		serr_out |-> $past(cmd_q[8]))
		else $error("error line driven while disabled");
	serr_flag_a: assert property ( // [R14]
		@(posedge mclk) disable iff (!rst_b)
		serr_out |-> flags[4])
		else $error("error line flag not set");
	abort_flag_a: assert property ( // [R16]
		@(posedge mclk) disable iff (!rst_b)
		tgt_abort |-> flags[1])
		else $error("target abort flag not set");
	mabort_flag_a: assert property ( // [R15]
		@(posedge mclk) disable iff (!rst_b)
		ma_s |=> flags[3])
		else $error("master abort flag not set");
	cmd_zero_a: assert property ( // [R12]
		@(posedge mclk) disable iff (!rst_b)
		(cmd_q == 16'h0000) |=> (!mst_go && !mem_claim))
		else $error("bus activity with command zero");
	dprep_gate_a: assert property ( // [R18]
		@(posedge mclk) disable iff (!rst_b)
		(!cmd_q[6] && !flags[0]) |=> !flags[0])
		else $error("parity report flag set while disabled");
endmodule

/* tb/pcf_host.sv */
`timescale 1ns/100ps
// Host bridge model issuing type 0 configuration cycles
module pcf_host (
	input  wire logic   mclk,       // Bus clock
	output logic        cfg_start,  // Address phase strobe
	output logic        cfg_write,  // Cycle is a write
	output logic        idsel,      // Device select
	output logic [10:0] cfg_addr,   // Address bits 10..0
	output logic        data_valid, // Data beat strobe
	output logic        data_last,  // Final beat
	output logic [3:0]  byte_en_b,  // Lanes, low active
	output logic [31:0] wdata       // Write data
);
	initial begin
		{cfg_start, cfg_write, idsel, data_valid, data_last} = '0;
		cfg_addr = '0;
		byte_en_b = 4'hf;
		wdata = '0;
	end

	// Caller picks select, function and low address bits
	task automatic xfer(input logic wr, input logic sel,
		input logic [10:0] a, input int n, input logic [3:0] be,
		input logic [31:0] d [4]);
		@(posedge mclk);
		#1;
		{cfg_start, cfg_write, idsel} = {1'b1, wr, sel};
		cfg_addr = a;
		for (int i = 0; i < n; i++) begin
			@(posedge mclk);
			#1;
			// Released lines take the inverse of their address-phase value
			{cfg_start, idsel} = {1'b0, ~sel};
			cfg_addr = ~a;
			{data_valid, data_last} = {1'b1, i == n - 1};
			byte_en_b = be;
			wdata = wr ? d[i] : ~wdata;
		end
		@(posedge mclk);
		#1;
		{data_valid, data_last} = 2'b00;
		byte_en_b = 4'hf;
		wdata = ~wdata;
		// Turn cycle before the next start
		repeat (2) @(posedge mclk);
	endtask
endmodule

/* tb/tb_pcf_cfg.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; \
	if ((g) !== (e)) begin miscompares++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module tb_pcf_cfg;
	localparam logic [31:0] ID_WORD = 32'h0a5c_3c1b; // Arbitrary
	logic        mclk, rst_b, cfg_start, cfg_write, idsel, data_valid;
	logic        data_last, addr_perr, data_perr, mst_read, tgt_perr;
	logic        mst_mabort, mst_tabort, mst_req, mem_hit, cfg_claim;
	logic        rdata_vld, tgt_abort, serr_out, perr_out, mst_go, mem_claim;
	logic        ta_seen = 1'b0, se_seen = 1'b0, pe_seen = 1'b0;
	logic [10:0] cfg_addr;
	logic [3:0]  byte_en_b;
	logic [31:0] wdata, rdata, exp_w;
	logic [15:0] cmd_m, st_m;
	logic [31:0] q [$];
	logic [31:0] d [4];
	logic [11:0] bad [3] = '{12'h004, 12'h805, 12'h904};
	int          miscompares = 0;
	int          samples_checked = 0;

	pcf_cfg #(.DEVICE_ID(ID_WORD[31:16]),
		.MAKER_ID(ID_WORD[15:0])) i_pcf_cfg (
		.mclk, .rst_b, .cfg_start, .cfg_write, .idsel, .cfg_addr, .data_valid,
		.data_last, .byte_en_b, .wdata, .addr_perr, .data_perr, .mst_read,
		.tgt_perr, .mst_mabort, .mst_tabort, .mst_req, .mem_hit, .cfg_claim,
		.rdata, .rdata_vld, .tgt_abort, .serr_out, .perr_out, .mst_go,
		.mem_claim);
	pcf_host i_pcf_host (.mclk, .cfg_start, .cfg_write, .idsel, .cfg_addr,
		.data_valid, .data_last, .byte_en_b, .wdata);

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	function automatic logic [31:0] lanes(input logic [3:0] be);
		for (int i = 0; i < 4; i++) lanes[8*i+:8] = {8{~be[i]}};
	endfunction

	function automatic logic [31:0] regv(input logic [5:0] ix);
		return ix == 6'h00 ? ID_WORD : ix == 6'h01 ?
			{st_m | 16'h0280, cmd_m} : 32'h0000_0000;
	endfunction

	// Configuration access; notes expected read data, updates model
	task automatic acc(input logic wr, input logic sel, input logic [10:0] a,
		input int n, input logic [3:0] be);
		logic [31:0] m;
		m = lanes(be);
		if (sel && a[10:8] == 3'h0 && a[1:0] == 2'h0)
			for (int i = 0; i < n; i++)
				if (!wr) q.push_back(regv(a[7:2] + 6'(i)) & m);
				else if (a[7:2] + 6'(i) == 6'h01) begin
					cmd_m = (cmd_m & ~(m[15:0] & 16'h0146)) |
						(d[i][15:0] & m[15:0] & 16'h0146);
					st_m = st_m & ~(d[i][31:16] & m[31:16] & 16'hf900);
				end
		i_pcf_host.xfer(wr, sel, a, n, be, d);
	endtask

	// Pins high bit first: address parity, data parity, master abort,
	// target abort, target parity; b holds the status bits expected to rise
	task automatic ev(input logic [4:0] s, input logic rd,
		input logic [15:0] b);
		@(posedge mclk);
		#1;
		{addr_perr, data_perr, mst_mabort, mst_tabort, tgt_perr} = s;
		mst_read = rd;
		repeat (6) @(posedge mclk);
		#1;
		{addr_perr, data_perr, mst_mabort, mst_tabort, tgt_perr} = 5'h00;
		repeat (4) @(posedge mclk);
		st_m = st_m | b;
	endtask

	task automatic do_reset();
		#1;
		rst_b = 1'b0;
		repeat (4) @(posedge mclk);
		#1;
		rst_b = 1'b1;
		{cmd_m, st_m} = '0;
	endtask

	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Scoreboard: oldest note against each read beat
	always @(posedge mclk) begin
		if (tgt_abort === 1'b1) ta_seen <= 1'b1;
		if (serr_out === 1'b1) se_seen <= 1'b1;
		if (perr_out === 1'b1) pe_seen <= 1'b1;
		if (rdata_vld === 1'b1) begin
			exp_w = q.size() > 0 ? q.pop_front() : 32'hxxxx_xxxx;
			`CHK("rdata", exp_w, rdata)
		end
	end

	initial begin
		repeat (3000) @(posedge mclk);
		miscompares++;
		stop_test();
	end

	initial begin
		{addr_perr, data_perr, mst_read, tgt_perr} = '0;
		{mst_mabort, mst_tabort, mst_req, mem_hit} = '0;
		void'($urandom(18621));
		do_reset();
		acc(0, 1, 11'h000, 4, 4'h0);
		acc(0, 1, 11'h030, 4, 4'h0);
		d = '{$urandom, $urandom, 0, 0};
		acc(1, 1, 11'h000, 2, 4'h0);
		acc(0, 1, 11'h000, 2, 4'h0);
		$display("Test reset, burst and identity done");
		d = '{32'hffff_ffff, 0, 0, 0};
		acc(1, 1, 11'h004, 1, 4'b1110);
		acc(1, 1, 11'h004, 1, 4'b1101);
		foreach (bad[k]) fork
			acc(1, bad[k][11], bad[k][10:0], 1, 4'h0);
			repeat (5) @(posedge mclk) `CHK("claim", 1'b0, cfg_claim)
		join
		acc(0, 1, 11'h004, 1, 4'b0011);
		acc(0, 1, 11'h004, 1, 4'b1100);
		$display("Test lanes and refusals done");
		ev(5'h04, 0, 16'h2000);
		ev(5'h02, 0, 16'h1000);
		ev(5'h08, 0, 16'h8000);
		acc(0, 1, 11'h004, 1, 4'h0);
		d = '{0, 0, 0, 0};
		acc(1, 1, 11'h004, 1, 4'h0);
		acc(0, 1, 11'h004, 1, 4'h0);
		d = '{$urandom, 0, 0, 0};
		acc(1, 1, 11'h004, 1, 4'h0);
		acc(0, 1, 11'h004, 1, 4'h0);
		d = '{32'h0000_0146, 0, 0, 0};
		acc(1, 1, 11'h004, 1, 4'h0);
		ev(5'h10, 0, 16'hc800);
		ev(5'h01, 0, 16'h0100);
		ev(5'h08, 1, 16'h8100);
		acc(0, 1, 11'h004, 1, 4'h0);
		`CHK("tgt_abort", 1'b1, ta_seen)
		`CHK("serr_out", 1'b1, se_seen)
		`CHK("perr_out", 1'b1, pe_seen)
		// Ones to every sticky flag, zero to the whole command field
		d = '{32'hffff_0000, 0, 0, 0};
		acc(1, 1, 11'h004, 1, 4'h0);
		acc(0, 1, 11'h004, 1, 4'h0);
		$display("Test status events done");
		#1;
		{mst_req, mem_hit} = 2'b11;
		repeat (3) @(posedge mclk);
		`CHK("mst_go", 1'b0, mst_go)
		`CHK("mem_claim", 1'b0, mem_claim)
		d = '{32'h0000_0006, 0, 0, 0};
		acc(1, 1, 11'h004, 1, 4'h0);
		acc(0, 1, 11'h004, 1, 4'h0);
		`CHK("mst_go", 1'b1, mst_go)
		`CHK("mem_claim", 1'b1, mem_claim)
		do_reset();
		acc(0, 1, 11'h004, 1, 4'h0);
		`CHK("mst_go", 1'b0, mst_go)
		$display("Test enables and second reset done");
		`CHK("pending", 0, q.size())
		stop_test();
	end
endmodule
